// ==== lbf_pkg.sv ====
// constants and types for the led boost fault supervisor
`default_nettype none
// How it works
// - on enable, output feedback low for 80 ms in the check phase latches off.
// - a latch-off holds until power is cycled or enable drops and rises.
// - switch current above the short level on three consecutive switch cycles latches off.
// - led feedback at its overvoltage level stops switching and latches.
// - output feedback above its overvoltage level inhibits raising.
// - output overvoltage held for more than 640 ms latches off.
// - with led feedback low the output keeps rising until a limit hits.
// - led feedback low with over-voltage or over-current for 60 ms latches.
// - over-temperature shuts down at once and restarts when it clears.
// - input undervoltage powers off and resumes when it clears.
// - the fault pin is driven low normally and released on any fault.
// - the soft-start reference is discharged while latched off.
package lbf_pkg;
    localparam int CLK_MHZ = 200;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC_DFLT = TICK_MS * CLK_MHZ * 1000;
    localparam int DIV_W = 18;
    localparam int DIODE_OPEN_MS = 80;
    localparam int OVER_HOLD_MS = 640;
    localparam int LED_OPEN_MS = 60;
    localparam int SHORT_CYCLES = 3;
    localparam int TMR_W = 10;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] INT_EN_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] INT_CLR_OFS = 8'h10;
    localparam int CTRL_SW_EN = 0;
    localparam logic CTRL_RST = 1'h1;
    localparam int STAT_SW = 3;
    localparam int STAT_FAULT = 4;
    localparam int STAT_LIVE_LSB = 16;
    localparam int STAT_CAUSE_LSB = 8;
    localparam int EV_W = 7;
    localparam int LATCH_EVS = 5;
    localparam int EV_DOPEN = 0;
    localparam int EV_DSHORT = 1;
    localparam int EV_LSHORT = 2;
    localparam int EV_OVER = 3;
    localparam int EV_LOPEN = 4;
    localparam int EV_UV = 5;
    localparam int EV_HOT = 6;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_CHECK,
        ST_RUN,
        ST_RETRY,
        ST_LATCH
    } lbf_state_type;
endpackage
`default_nettype wire

// ==== lbf_timer_if.sv ====
// carrier between the supervisor and one fault timer
`default_nettype none
interface lbf_timer_if;
    logic tick;
    logic cond;
    logic expired;
    modport owner (output tick, output cond, input expired);
    modport timer (input tick, input cond, output expired);
endinterface
`default_nettype wire

// ==== lbf_fault_timer.sv ====
// millisecond duration qualifier for one fault condition
`default_nettype none
module lbf_fault_timer
    import lbf_pkg::*;
#(
    parameter logic [TMR_W-1:0] LIMIT_MS = 10'h050
)
(
    input wire logic pclk,
    input wire logic presetn,
    lbf_timer_if.timer tif
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic expired;
    } lbf_tmr_type;

    lbf_tmr_type r_ff;
    lbf_tmr_type nxt_r;

    always_comb
    begin
        nxt_r = r_ff;
        if (!tif.cond)
        begin
            nxt_r.cnt = '0;
            nxt_r.expired = 1'b0;
        end
        else if (tif.tick && !r_ff.expired)
        begin
            // counting one past the limit makes it strictly longer
            if (r_ff.cnt == LIMIT_MS)
                nxt_r.expired = 1'b1;
            else
                nxt_r.cnt = r_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign tif.expired = r_ff.expired;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_timer_zero: assert property (
        !tif.cond |=> r_ff.cnt == '0 && !tif.expired)
        else $error("timer did not restart");
    a_timer_late: assert property (
        $rose(tif.expired) |-> $past(r_ff.cnt) == LIMIT_MS && $past(tif.tick))
        else $error("timer expired at wrong count");
endmodule
`default_nettype wire

// ==== lbf_supervisor.sv ====
// fault supervisor for a single-string led boost controller
//
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
module lbf_supervisor
    import lbf_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DFLT,
    parameter logic [TMR_W-1:0] OPEN_MS = TMR_W'(DIODE_OPEN_MS),
    parameter logic [TMR_W-1:0] OVER_MS = TMR_W'(OVER_HOLD_MS),
    parameter logic [TMR_W-1:0] LED_MS = TMR_W'(LED_OPEN_MS)
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable,
    input wire logic output_feedback_sense_low,
    input wire logic output_feedback_sense_over,
    input wire logic led_current_feedback_low,
    input wire logic led_current_feedback_over,
    input wire logic switch_current_sense_over,
    input wire logic switch_current_sense_short,
    input wire logic switch_cycle,
    input wire logic input_undervoltage_sense_low,
    input wire logic temp_over,
    output logic switch_en,
    output logic out_clamp,
    output logic raise_req,
    output logic ref_discharge,
    output logic fault_o,
    output logic fault_oe,
    output logic irq
);
    typedef struct packed {
        lbf_state_type st;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [1:0] short_cnt;
        logic short_hit;
        logic ctrl_en;
        logic [EV_W-1:0] int_stat;
        logic [EV_W-1:0] int_en;
        logic [LATCH_EVS-1:0] cause;
        logic [31:0] rdata;
    } lbf_main_type;

    lbf_main_type r_ff;
    lbf_main_type nxt_r;

    lbf_timer_if t_open ();
    lbf_timer_if t_over ();
    lbf_timer_if t_led ();

    logic en;
    logic active;
    logic hot;
    logic uv;
    logic short_now;
    logic short_trip;
    logic latch_ev;
    logic retry_ev;
    logic setup;
    logic access;
    logic wr;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [31:0] rd_val;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return a == CTRL_OFS || a == STATUS_OFS || a == INT_STAT_OFS ||
            a == INT_EN_OFS || a == INT_CLR_OFS;
    endfunction

    lbf_fault_timer #(
        .LIMIT_MS(OPEN_MS)
    ) u_open (
        .pclk(pclk),
        .presetn(presetn),
        .tif(t_open.timer)
    );

    lbf_fault_timer #(
        .LIMIT_MS(OVER_MS)
    ) u_over (
        .pclk(pclk),
        .presetn(presetn),
        .tif(t_over.timer)
    );

    lbf_fault_timer #(
        .LIMIT_MS(LED_MS)
    ) u_led (
        .pclk(pclk),
        .presetn(presetn),
        .tif(t_led.timer)
    );

    assign en = enable && r_ff.ctrl_en;
    assign active = r_ff.st == ST_CHECK || r_ff.st == ST_RUN;
    assign hot = temp_over;
    assign uv = input_undervoltage_sense_low;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign short_now = r_ff.short_hit || switch_current_sense_short;
    assign short_trip = r_ff.st == ST_RUN && switch_cycle && short_now &&
        r_ff.short_cnt == 2'(SHORT_CYCLES - 1);

    assign t_open.tick = r_ff.tick;
    assign t_over.tick = r_ff.tick;
    assign t_led.tick = r_ff.tick;
    assign t_open.cond = r_ff.st == ST_CHECK && output_feedback_sense_low;
    assign t_over.cond = r_ff.st == ST_RUN && output_feedback_sense_over;
    // led open or feedback short timer
    assign t_led.cond = r_ff.st == ST_RUN && led_current_feedback_low &&
        (output_feedback_sense_over || switch_current_sense_over);

    always_comb
    begin
        ev = '0;
        if (r_ff.st == ST_CHECK)
            ev[EV_DOPEN] = t_open.expired;
        if (r_ff.st == ST_RUN)
        begin
            ev[EV_DSHORT] = short_trip;
            ev[EV_OVER] = t_over.expired;
            ev[EV_LOPEN] = t_led.expired;
        end
        if (active)
        begin
            ev[EV_LSHORT] = led_current_feedback_over;
            ev[EV_UV] = uv;
            ev[EV_HOT] = hot;
        end
    end

    assign latch_ev = |ev[LATCH_EVS-1:0];
    assign retry_ev = ev[EV_UV] || ev[EV_HOT];
    assign clr = wr && paddr == INT_CLR_OFS ? pwdata[EV_W-1:0] : '0;

    always_comb
    begin
        rd_val = '0;
        unique case (paddr)
            CTRL_OFS:
                rd_val[CTRL_SW_EN] = r_ff.ctrl_en;
            STATUS_OFS:
            begin
                rd_val[2:0] = r_ff.st;
                rd_val[STAT_SW] = switch_en;
                rd_val[STAT_FAULT] = !fault_oe;
                rd_val[STAT_CAUSE_LSB +: LATCH_EVS] = r_ff.cause;
                rd_val[STAT_LIVE_LSB +: 7] = {temp_over, uv,
                    switch_current_sense_over, led_current_feedback_low,
                    led_current_feedback_over, output_feedback_sense_over,
                    output_feedback_sense_low};
            end
            INT_STAT_OFS:
                rd_val[EV_W-1:0] = r_ff.int_stat;
            INT_EN_OFS:
                rd_val[EV_W-1:0] = r_ff.int_en;
            default:
                rd_val = '0;
        endcase
    end

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.tick = 1'b0;
        if (r_ff.div == DIV_W'(TICK_CYC - 1))
        begin
            nxt_r.div = '0;
            nxt_r.tick = 1'b1;
        end
        else
            nxt_r.div = r_ff.div + 1'b1;

        if (r_ff.st == ST_RUN)
        begin
            if (switch_cycle)
            begin
                nxt_r.short_cnt = short_now ? r_ff.short_cnt + 1'b1 : '0;
                nxt_r.short_hit = 1'b0;
            end
            else if (switch_current_sense_short)
                nxt_r.short_hit = 1'b1;
        end
        else
        begin
            nxt_r.short_cnt = '0;
            nxt_r.short_hit = 1'b0;
        end

        unique case (r_ff.st)
            ST_OFF:
            begin
                nxt_r.cause = '0;
                if (en)
                    nxt_r.st = ST_CHECK;
            end
            ST_CHECK, ST_RUN:
            begin
                if (!en)
                    nxt_r.st = ST_OFF;
                else if (latch_ev)
                begin
                    nxt_r.st = ST_LATCH;
                    nxt_r.cause = ev[LATCH_EVS-1:0];
                end
                else if (retry_ev)
                    nxt_r.st = ST_RETRY;
                else if (r_ff.st == ST_CHECK && !output_feedback_sense_low)
                    nxt_r.st = ST_RUN;
            end
            ST_RETRY:
            begin
                if (!en)
                    nxt_r.st = ST_OFF;
                else if (!uv && !hot)
                    nxt_r.st = ST_CHECK;
            end
            ST_LATCH:
            begin
                if (!en)
                    nxt_r.st = ST_OFF;
            end
        endcase

        if (setup)
            nxt_r.rdata = rd_val;
        if (wr && paddr == CTRL_OFS)
            nxt_r.ctrl_en = pwdata[CTRL_SW_EN];
        if (wr && paddr == INT_EN_OFS)
            nxt_r.int_en = pwdata[EV_W-1:0];
        // a clear in the same cycle as an event loses to the event
        nxt_r.int_stat = (r_ff.int_stat & ~clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_ff <= '0;
            r_ff.st <= ST_OFF;
            r_ff.ctrl_en <= CTRL_RST;
        end
        else
            r_ff <= nxt_r;
    end

    // zero wait states; read data was captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = r_ff.rdata;
    assign pslverr = access && !reg_hit(paddr);

    assign switch_en = r_ff.st == ST_RUN && !led_current_feedback_over &&
        !uv && !hot;
    assign out_clamp = switch_en && output_feedback_sense_over;
    assign raise_req = switch_en && led_current_feedback_low &&
        !output_feedback_sense_over && !switch_current_sense_over;
    assign ref_discharge = r_ff.st == ST_LATCH;
    assign fault_o = 1'b0;
    assign fault_oe = !(r_ff.st == ST_LATCH || r_ff.st == ST_RETRY);
    assign irq = |(r_ff.int_stat & r_ff.int_en);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_short_cycle;
        r_ff.st == ST_RUN && switch_cycle && short_now;
    endsequence
    sequence s_latched_short;
        r_ff.st == ST_LATCH && r_ff.cause[EV_DSHORT];
    endsequence

    a_latch_holds: assert property (
        r_ff.st == ST_LATCH && en |=> r_ff.st == ST_LATCH && ref_discharge)
        else $error("latch released while enabled");
    a_led_short_stop: assert property (
        active && en && led_current_feedback_over
        |-> !switch_en ##1 r_ff.st == ST_LATCH)
        else $error("led feedback overvoltage did not latch");
    a_over_no_raise: assert property (
        output_feedback_sense_over |-> !raise_req)
        else $error("raise requested above overvoltage");
    a_short_three: assert property (
        s_short_cycle and r_ff.short_cnt == 2'h2 && en
        |=> s_latched_short)
        else $error("third short cycle did not latch");
    a_open_latch: assert property (
        r_ff.st == ST_CHECK && en && t_open.expired |=> r_ff.st == ST_LATCH)
        else $error("topology fault did not latch");
    a_retry_back: assert property (
        r_ff.st == ST_RETRY && en && !uv && !hot |=> r_ff.st == ST_CHECK)
        else $error("retry did not resume");
    a_fault_pin: assert property (
        $rose(r_ff.st == ST_LATCH) |-> !fault_oe ##1 !fault_oe || !en)
        else $error("fault pin driven during fault");
    a_set_wins: assert property (
        |ev |=> (r_ff.int_stat & $past(ev)) == $past(ev) && (irq ||
            (r_ff.int_en & $past(ev)) == '0))
        else $error("event lost from status");

    sequence s_latched_over;
        r_ff.st == ST_LATCH && r_ff.cause[EV_OVER];
    endsequence
    sequence s_latched_open;
        r_ff.st == ST_LATCH && r_ff.cause[EV_LOPEN];
    endsequence
    a_over_latch: assert property (
        r_ff.st == ST_RUN && en && t_over.expired |=> s_latched_over)
        else $error("overvoltage hold did not latch");
    a_open_led_latch: assert property (
        r_ff.st == ST_RUN && en && t_led.expired |=> s_latched_open)
        else $error("led open did not latch");
    a_retry_enter: assert property (
        active && en && (uv || hot) && !latch_ev |=> r_ff.st == ST_RETRY)
        else $error("retry fault did not power off");
    a_run_pin_low: assert property (
        r_ff.st == ST_RUN |-> fault_oe && !fault_o)
        else $error("fault pin released in normal running");
    a_latch_quiet: assert property (
        ref_discharge |-> !switch_en && !raise_req && !out_clamp)
        else $error("switching while discharged");
    a_check_first: assert property (
        r_ff.st == ST_OFF && en |=> r_ff.st == ST_CHECK && !switch_en)
        else $error("enable skipped the topology check");
endmodule
`default_nettype wire

// ==== lbf_power_stage.sv ====
// model of the boost power stage and its switch current comparator
`default_nettype none
module lbf_power_stage
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic switch_en,
    input wire logic diode_shorted,
    output logic switch_cycle,
    output logic short_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] phase_ff;
    // a stopped stage makes no cycle pulses, so the count cannot creep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_ff <= 2'h0;
        else if (switch_en)
            phase_ff <= phase_ff + 2'h1;
    end
    assign switch_cycle = switch_en && phase_ff == 2'h3;
    // shorted diode shows as a spike early in the on-time
    assign short_seen = switch_en && diode_shorted && phase_ff == 2'h1;
endmodule
`default_nettype wire

// ==== lbf_supervisor_test.sv ====
// self-checking testbench of the led boost fault supervisor
`default_nettype none
module lbf_supervisor_test
    import lbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic en = 1'b0;
    logic ofl = 1'b0, ofo = 1'b0, lcl = 1'b0, lco = 1'b0;
    logic sco = 1'b0, uvl = 1'b0, hot = 1'b0, sh = 1'b0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, serr, scs, cyc, switch_en, out_clamp;
    logic raise_req, ref_discharge, fault_o, fault_oe, irq;
    int n_errors = 0;
    int cmp_count = 0;
    int n;
    // open-drain pin with its pull-up
    wire logic fault_pin = fault_oe ? fault_o : 1'b1;
    always #2.5 pclk = ~pclk;
    lbf_supervisor #(.TICK_CYC(T), .OPEN_MS(10'h003), .OVER_MS(10'h004),
        .LED_MS(10'h003)) lbf_supervisor_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable(en), .output_feedback_sense_low(ofl),
        .output_feedback_sense_over(ofo), .led_current_feedback_low(lcl),
        .led_current_feedback_over(lco), .switch_current_sense_over(sco),
        .switch_current_sense_short(scs), .switch_cycle(cyc),
        .input_undervoltage_sense_low(uvl), .temp_over(hot),
        .switch_en(switch_en), .out_clamp(out_clamp),
        .raise_req(raise_req), .ref_discharge(ref_discharge),
        .fault_o(fault_o), .fault_oe(fault_oe), .irq(irq));
    lbf_power_stage lbf_power_stage_inst (.pclk(pclk),
        .presetn(presetn), .switch_en(switch_en), .diode_shorted(sh),
        .switch_cycle(cyc), .short_seen(scs));
    task conclude;
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wl;
        n = 0;
        while (ref_discharge !== 1'b1 && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
    endtask
    task rng(input int lim);
        chk("latch delay", 1, 32'(n >= lim * T + 1 && n <= lim * T + T + 5));
    endtask
    task wcyc(input int k);
        repeat (k)
        begin
            @(posedge pclk);
            while (cyc !== 1'b1)
                @(posedge pclk);
        end
    endtask
    task rs;
        {ofl, ofo, lcl, lco, sco, uvl, hot, sh} <= '0;
        en <= 1'b0;
        repeat (3) @(posedge pclk);
        en <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("switch_en", 1, switch_en);
        chk("fault pin", 0, fault_pin);
        chk("ref_discharge", 0, ref_discharge);
    endtask
    task lat(input int b);
        chk("fault pin", 1, fault_pin);
        chk("switch_en", 0, switch_en);
        chk("ref_discharge", 1, ref_discharge);
        chk("irq", 1, irq);
        bus(1'b0, INT_STAT_OFS, '0);
        chk("int_stat", 32'h1 << b, rdat);
        bus(1'b1, INT_CLR_OFS, 32'h7f);
        @(posedge pclk);
        chk("irq cleared", 0, irq);
    endtask
    initial
    begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk("fault pin", 0, fault_pin);
        bus(1'b0, CTRL_OFS, '0);
        chk("ctrl", 32'h1, rdat);
        bus(1'b0, 8'h40, '0);
        chk("unmapped err", 1, serr);
        bus(1'b1, INT_EN_OFS, 32'h7f);
        ofl <= 1'b1;
        en <= 1'b1;
        wl();
        rng(3);
        lat(EV_DOPEN);
        {uvl, hot} <= 2'h3;
        repeat (3) @(posedge pclk);
        {uvl, hot} <= 2'h0;
        repeat (4) @(posedge pclk);
        chk("latch kept", 1, ref_discharge);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b1, INT_EN_OFS, 32'h7f);
        chk("power cycle", 0, ref_discharge);
        rs();
        lcl <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("raise_req", 1, raise_req);
        ofo <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("raise_req", 0, raise_req);
        chk("out_clamp", 1, out_clamp);
        lcl <= 1'b0;
        repeat (26) @(posedge pclk);
        ofo <= 1'b0;
        repeat (2) @(posedge pclk);
        ofo <= 1'b1;
        wl();
        rng(4);
        lat(EV_OVER);
        rs();
        {lcl, sco} <= 2'h3;
        wl();
        rng(3);
        lat(EV_LOPEN);
        rs();
        lco <= 1'b1;
        @(posedge pclk);
        chk("switch_en", 0, switch_en);
        @(posedge pclk);
        lat(EV_LSHORT);
        rs();
        wcyc(1);
        sh <= 1'b1;
        wcyc(2);
        sh <= 1'b0;
        wcyc(1);
        sh <= 1'b1;
        wcyc(2);
        chk("two shorts", 0, ref_discharge);
        wcyc(1);
        repeat (2) @(posedge pclk);
        sh <= 1'b0;
        lat(EV_DSHORT);
        rs();
        bus(1'b1, INT_EN_OFS, '0);
        for (int i = 0; i < 2; i++)
        begin
            {uvl, hot} <= (i == 0) ? 2'h1 : 2'h2;
            repeat (2) @(posedge pclk);
            chk("switch_en", 0, switch_en);
            chk("fault pin", 1, fault_pin);
            chk("irq masked", 0, irq);
            {uvl, hot} <= 2'h0;
            repeat (6) @(posedge pclk);
            chk("resumed", 1, switch_en);
            chk("fault pin", 0, fault_pin);
        end
        bus(1'b0, INT_STAT_OFS, '0);
        chk("int_stat", 32'h60, rdat);
        bus(1'b1, INT_EN_OFS, 32'h60);
        @(posedge pclk);
        chk("irq", 1, irq);
        bus(1'b1, INT_CLR_OFS, 32'h60);
        @(posedge pclk);
        chk("irq cleared", 0, irq);
        // software enable off and on again
        bus(1'b1, CTRL_OFS, '0);
        @(posedge pclk);
        chk("ctrl off", 0, switch_en);
        bus(1'b1, CTRL_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        chk("ctrl on", 1, switch_en);
        bus(1'b0, STATUS_OFS, '0);
        chk("status", (32'h1 << STAT_SW) | 32'h2, rdat);
        conclude();
    end
endmodule
`default_nettype wire
